/* File: rtl/sss_top.sv */
/*
  Four-channel supply sequencer and supervisor with an AXI4-Lite slave.
  Assumes comparator results arrive as asynchronous pins, one clock CLK.
*/
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
//
// Notes on behaviour
// - Run request rising starts sequence-up and samples all position selects.
// - While sequencing, the slot strobe goes low at each time position start.
// - Comparator-good outputs stay low while sequencing unless a fault exists.
// - Sequence-complete goes low after all eight time positions.
// - After sequence-up, comparator-good follows each supply's undervoltage check.
// - Reset releases after all supplies stay good for the reset delay.
// - Reset release moves the device into the supply-monitor phase.
// - In monitoring, any supply below threshold pulls reset low.
// - Monitor undervoltage counted as fault drives fault line and all drives low.
// - After a fault, no new sequence until supplies off and run low.
// - Run request falling starts sequence-down; reset and comparator-good go low.
// - Sequence-down turns supplies off in reverse order from position eight.
// - Sequence-complete goes high after sequence-down's eight positions.
// - Any supply above overvoltage threshold pulls the alarm low, any phase.
// - Alarm releases after all supplies stay below overvoltage for reset delay.
// - Threshold select sets overvoltage margin: open 32, ground 12, supply 115.
// - A time position ends when the slot timer expires and its supplies are above the sequence threshold in sequence-up, below it in sequence-down.
// - Power-good timer expiry before all supplies reach target is a fault.
// - Both role selects grounded makes monitor-phase reset a reset fault.
`timescale 1ns/10ps
`include "sss_cfg.svh"
module sss_top #(
  parameter int unsigned CH = `SSS_CHANNELS,
  parameter int unsigned STMR_CYC = `SSS_STMR_US * `SSS_CLK_MHZ,
  parameter int unsigned PTMR_CYC = `SSS_PTMR_US * `SSS_CLK_MHZ,
  parameter int unsigned RTMR_CYC = `SSS_RTMR_US * `SSS_CLK_MHZ
) (
  input wire logic CLK,                      // 50 MHz clock
  input wire logic RST_N,                    // Asynchronous reset, active low
  input wire logic CE,                       // Clock enable
  input wire logic RUN_REQ,                  // Run request comparator
  input wire logic [CH-1:0] SUPPLY_UV_OK,    // Above undervoltage threshold
  input wire logic [CH-1:0] SUPPLY_SEQ_OK,   // Above sequence threshold
  input wire logic [CH-1:0] SUPPLY_OV,       // Above overvoltage threshold
  input wire logic [CH*`SSS_POS_W-1:0] POSITION_SELECT, // Slot per channel
  input wire logic [1:0] ROLE_SELECT_A,      // Three-state role pin A
  input wire logic [1:0] ROLE_SELECT_B,      // Three-state role pin B
  input wire logic [1:0] HIGH_THRESHOLD_SELECT, // Three-state margin pin
  input wire logic FAULT_LINE_I,             // Fault line level
  output logic FAULT_LINE_O,                 // Fault line drive value
  output logic FAULT_LINE_OE,                // Fault line pulled low
  output logic [CH-1:0] CHANNEL_DRIVE,       // Supply enables
  output logic [CH-1:0] COMPARATOR_GOOD,     // Per-channel good
  output logic SLOT_STROBE_N,                // Time position strobe
  output logic SEQ_DONE_N,                   // Sequence complete
  output logic RST_OUT_N,                    // Processor reset
  output logic HIGH_SUPPLY_ALARM_N,          // Overvoltage alarm
  output logic [7:0] OV_MARGIN_PCT,          // Overvoltage margin setting
  input wire logic [7:0] AWADDR,             // AXI write address
  input wire logic AWVALID,                  // AXI write address valid
  output logic AWREADY,                      // AXI write address ready
  input wire logic [31:0] WDATA,             // AXI write data
  input wire logic [3:0] WSTRB,              // AXI write strobes
  input wire logic WVALID,                   // AXI write data valid
  output logic WREADY,                       // AXI write data ready
  output logic [1:0] BRESP,                  // AXI write response
  output logic BVALID,                       // AXI write response valid
  input wire logic BREADY,                   // AXI write response ready
  input wire logic [7:0] ARADDR,             // AXI read address
  input wire logic ARVALID,                  // AXI read address valid
  output logic ARREADY,                      // AXI read address ready
  output logic [31:0] RDATA,                 // AXI read data
  output logic [1:0] RRESP,                  // AXI read response
  output logic RVALID,                       // AXI read valid
  input wire logic RREADY                    // AXI read ready
);

  localparam int unsigned PW = `SSS_POS_W;
  localparam int unsigned SW = 2 + 3 * CH + CH * PW + 6;

  logic [1:0] rs_q;
  logic rst_n;
  logic [SW-1:0] s1_q, s2_q;
  logic run_s, flt_in_s;
  logic [CH-1:0] uv_s, sq_s, ov_s;
  logic [CH*PW-1:0] pos_s;
  logic [3:0] role_s;
  logic [1:0] ovsel_s;
  sss_pkg::sss_phase_e phase_q;
  logic [CH*PW-1:0] pos_q;
  logic [PW-1:0] slot_q, eff_slot;
  logic gap_q, strobe_n_q, done_n_q, rst_n_q, flt_q, alarm_n_q, run_prev_q;
  logic pg_run_q, pg_used_q;
  logic [1:0] flt_h_q;
  logic [CH-1:0] drive_q, cmp_q, slot_ch;
  logic [7:0] ovpct_q;
  logic [1:0] ctrl_q;
  logic [2:0] cause_q;
  logic run_rise, run_fall, all_uv, all_off, any_ov, seqing, slot_met, slot_end;
  logic uv_fault, mon_uv, pg_target, seq_fault, ext_fault, fault_set, rel_ok;
  logic rst_win;
  logic slot_done, pg_done, rst_done, ov_done;
  logic aw_have_q, w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [31:0] rd_d;
  logic [1:0] rresp_d;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers

  // Release reset through two flops
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rs_q <= 2'h0;
    end else if (CE) begin
      rs_q <= {rs_q[0], 1'b1};
    end
  end
  assign rst_n = rs_q[1];

  // Two flops on every asynchronous pin
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= {2'b01, {(SW - 2){1'b0}}}; // Fault line idles high
      s2_q <= {2'b01, {(SW - 2){1'b0}}};
    end else if (CE) begin
      s1_q <= {RUN_REQ, FAULT_LINE_I, SUPPLY_UV_OK, SUPPLY_SEQ_OK, SUPPLY_OV,
               POSITION_SELECT, ROLE_SELECT_A, ROLE_SELECT_B, HIGH_THRESHOLD_SELECT};
      s2_q <= s1_q;
    end
  end
  assign {run_s, flt_in_s, uv_s, sq_s, ov_s, pos_s, role_s, ovsel_s} = s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Conditions

  // Supply summaries and slot membership
  assign run_rise = run_s & ~run_prev_q;
  assign run_fall = ~run_s & run_prev_q;
  assign all_uv = &uv_s;
  assign all_off = ~|sq_s;
  assign any_ov = |ov_s;
  assign seqing = (phase_q == sss_pkg::SSS_UP) | (phase_q == sss_pkg::SSS_DOWN);
  assign eff_slot = (phase_q == sss_pkg::SSS_DOWN) ? ~slot_q : slot_q;
  always_comb begin
    for (int i = 0; i < CH; i++) begin
      slot_ch[i] = (pos_q[i*PW +: PW] == eff_slot);
    end
  end
  assign slot_met = (phase_q == sss_pkg::SSS_DOWN) ? &(~slot_ch | ~sq_s)
                                                   : &(~slot_ch | sq_s);
  assign slot_end = seqing && !gap_q && !strobe_n_q && slot_done && slot_met;

  // Fault sources
  assign uv_fault = (role_s == 4'h0) | ctrl_q[`SSS_CTRL_UVF_BIT];
  assign mon_uv = (phase_q == sss_pkg::SSS_MON) && !all_uv;
  assign pg_target = (phase_q == sss_pkg::SSS_DOWN) ? all_off : all_uv;
  assign seq_fault = pg_run_q && pg_done && !pg_target;
  // Own pull-down echoes back through the synchroniser for two cycles
  assign ext_fault = !flt_in_s && !flt_q && !(|flt_h_q);
  assign fault_set = (phase_q != sss_pkg::SSS_FAULT) &&
                     ((mon_uv && uv_fault) || seq_fault || ext_fault);
  assign rel_ok = !run_s && all_off;
  assign rst_win = ((phase_q == sss_pkg::SSS_UP && !done_n_q) ||
                    phase_q == sss_pkg::SSS_MON) && !run_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Timers

  // Slot spacing, counts while the strobe is low
  sss_timer #(.LIMIT(STMR_CYC)) u_slot_tmr (
    .clk(CLK), .rst_n(rst_n), .ce(CE), .restart(strobe_n_q), .done_q(slot_done)
  );

  // Power-good window from the first switched channel
  sss_timer #(.LIMIT(PTMR_CYC)) u_pg_tmr (
    .clk(CLK), .rst_n(rst_n), .ce(CE), .restart(!pg_run_q), .done_q(pg_done)
  );

  // Reset delay, restarts on any undervoltage
  sss_timer #(.LIMIT(RTMR_CYC)) u_rst_tmr (
    .clk(CLK), .rst_n(rst_n), .ce(CE), .restart(!all_uv || !rst_win),
    .done_q(rst_done)
  );

  // Alarm release delay, restarts on any overvoltage
  sss_timer #(.LIMIT(RTMR_CYC)) u_ov_tmr (
    .clk(CLK), .rst_n(rst_n), .ce(CE), .restart(any_ov), .done_q(ov_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencer

  // Phases, slot stepping, strobe, completion and fault latch
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= sss_pkg::SSS_OFF;
      pos_q <= '0;
      slot_q <= '0;
      gap_q <= 1'b0;
      strobe_n_q <= 1'b1;
      done_n_q <= 1'b1;
      flt_q <= 1'b0;
      run_prev_q <= 1'b0;
      flt_h_q <= 2'h0;
    end else if (CE) begin
      run_prev_q <= run_s;
      flt_h_q <= {flt_h_q[0], flt_q};
      if (fault_set) begin
        phase_q <= sss_pkg::SSS_FAULT;
        flt_q <= 1'b1;
        gap_q <= 1'b0;
        strobe_n_q <= 1'b1;
      end else begin
        unique case (phase_q)
          sss_pkg::SSS_OFF: begin
            if (run_rise && ctrl_q[`SSS_CTRL_EN_BIT]) begin
              phase_q <= sss_pkg::SSS_UP;
              pos_q <= pos_s;
              slot_q <= '0;
              strobe_n_q <= 1'b0;
            end
          end
          sss_pkg::SSS_UP, sss_pkg::SSS_MON: begin
            if (run_fall) begin
              phase_q <= sss_pkg::SSS_DOWN;
              slot_q <= '0;
              gap_q <= 1'b0;
              strobe_n_q <= 1'b0;
            end else if (phase_q == sss_pkg::SSS_UP && !done_n_q && rst_n_q) begin
              phase_q <= sss_pkg::SSS_MON;
            end else if (phase_q == sss_pkg::SSS_UP && done_n_q) begin
              if (gap_q) begin
                gap_q <= 1'b0;
                slot_q <= slot_q + PW'(1);
                strobe_n_q <= 1'b0;
              end else if (slot_end) begin
                strobe_n_q <= 1'b1;
                gap_q <= (slot_q != `SSS_LAST_SLOT);
                done_n_q <= (slot_q != `SSS_LAST_SLOT);
              end
            end
          end
          sss_pkg::SSS_DOWN: begin
            if (gap_q) begin
              gap_q <= 1'b0;
              slot_q <= slot_q + PW'(1);
              strobe_n_q <= 1'b0;
            end else if (slot_end) begin
              strobe_n_q <= 1'b1;
              if (slot_q == `SSS_LAST_SLOT) begin
                done_n_q <= 1'b1;
                phase_q <= sss_pkg::SSS_OFF;
              end else begin
                gap_q <= 1'b1;
              end
            end
          end
          sss_pkg::SSS_FAULT: begin
            if (rel_ok) begin
              phase_q <= sss_pkg::SSS_OFF;
              flt_q <= 1'b0;
              done_n_q <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Channel drives switch at their slot, all off on fault
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      drive_q <= '0;
    end else if (CE) begin
      if (fault_set || phase_q == sss_pkg::SSS_FAULT) begin
        drive_q <= '0;
      end else if (seqing && !strobe_n_q && !gap_q) begin
        drive_q <= (phase_q == sss_pkg::SSS_UP) ? (drive_q | slot_ch)
                                                : (drive_q & ~slot_ch);
      end
    end
  end

  // Power-good window, armed once per sequence
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pg_run_q <= 1'b0;
      pg_used_q <= 1'b0;
    end else if (CE) begin
      if (!seqing || run_fall || fault_set) begin
        pg_run_q <= 1'b0;
        pg_used_q <= 1'b0;
      end else if (!pg_used_q && !strobe_n_q && |slot_ch) begin
        pg_run_q <= 1'b1;
        pg_used_q <= 1'b1;
      end else if (pg_target) begin
        pg_run_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supervisor outputs

  // Comparators, reset, alarm and margin setting
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cmp_q <= '0;
      rst_n_q <= 1'b0;
      alarm_n_q <= 1'b1;
      ovpct_q <= `SSS_OV_PCT_OPEN;
    end else if (CE) begin
      cmp_q <= (rst_win || phase_q == sss_pkg::SSS_FAULT) ? uv_s : '0;
      rst_n_q <= rst_win && all_uv && rst_done;
      if (any_ov) begin
        alarm_n_q <= 1'b0;
      end else if (ov_done) begin
        alarm_n_q <= 1'b1;
      end
      unique case (ovsel_s)
        `SSS_PIN_GND: ovpct_q <= `SSS_OV_PCT_GND;
        `SSS_PIN_VCC: ovpct_q <= `SSS_OV_PCT_VCC;
        default: ovpct_q <= `SSS_OV_PCT_OPEN;
      endcase
    end
  end

  assign FAULT_LINE_O = 1'b0;
  assign FAULT_LINE_OE = flt_q;
  assign CHANNEL_DRIVE = drive_q;
  assign COMPARATOR_GOOD = cmp_q;
  assign SLOT_STROBE_N = strobe_n_q;
  assign SEQ_DONE_N = done_n_q;
  assign RST_OUT_N = rst_n_q;
  assign HIGH_SUPPLY_ALARM_N = alarm_n_q;
  assign OV_MARGIN_PCT = ovpct_q;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  // Write address and data taken in either order, then one response
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= `SSS_RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (CE) begin
      AWREADY <= AWVALID && !AWREADY && !aw_have_q && !BVALID;
      WREADY <= WVALID && !WREADY && !w_have_q && !BVALID;
      if (AWVALID && AWREADY) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_have_q <= 1'b1;
        w_data_q <= WDATA;
        w_strb_q <= WSTRB;
      end
      if (aw_have_q && w_have_q && !BVALID) begin
        BVALID <= 1'b1;
        BRESP <= (aw_addr_q == `SSS_CTRL_OFS || aw_addr_q == `SSS_STATUS_OFS ||
                  aw_addr_q == `SSS_CAUSE_OFS) ? `SSS_RESP_OKAY : `SSS_RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
    end
  end

  // Control and sticky fault cause, set wins over clear
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `SSS_CTRL_RST;
      cause_q <= '0;
    end else if (CE) begin
      if (aw_have_q && w_have_q && !BVALID && w_strb_q[0] &&
          aw_addr_q == `SSS_CTRL_OFS) begin
        ctrl_q <= w_data_q[1:0];
      end
      cause_q <= (cause_q & ~((aw_have_q && w_have_q && !BVALID && w_strb_q[0] &&
                               aw_addr_q == `SSS_CAUSE_OFS) ? w_data_q[2:0] : 3'h0))
               | {ext_fault, seq_fault, mon_uv && uv_fault && !flt_q};
    end
  end

  // Read data selection
  always_comb begin
    rd_d = 32'h0;
    rresp_d = `SSS_RESP_OKAY;
    unique case (ARADDR)
      `SSS_CTRL_OFS: rd_d = 32'(ctrl_q);
      `SSS_STATUS_OFS: rd_d = 32'({slot_q, done_n_q, alarm_n_q, rst_n_q, cmp_q,
                                   drive_q, flt_q, phase_q});
      `SSS_CAUSE_OFS: rd_d = 32'(cause_q);
      default: rresp_d = `SSS_RESP_SLVERR;
    endcase
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= `SSS_RESP_OKAY;
    end else if (CE) begin
      ARREADY <= ARVALID && !ARREADY && !RVALID;
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RDATA <= rd_d;
        RRESP <= rresp_d;
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_strobe;
    @(posedge CLK) disable iff (!rst_n) (CE && gap_q && !fault_set) |=> !strobe_n_q;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe not low at slot start");

  property p_cmp_low;
    @(posedge CLK) disable iff (!rst_n)
      (phase_q == sss_pkg::SSS_UP && done_n_q && $past(phase_q) != sss_pkg::SSS_FAULT)
      |-> (cmp_q == '0);
  endproperty
  a_cmp_low: assert property (p_cmp_low) else $error("comparator good while sequencing");

  property p_done_up;
    @(posedge CLK) disable iff (!rst_n)
      (CE && phase_q == sss_pkg::SSS_UP && slot_end && slot_q == `SSS_LAST_SLOT
       && !fault_set && !run_fall) |=> !done_n_q;
  endproperty
  a_done_up: assert property (p_done_up) else $error("done not low after eight slots");

  property p_rst_rel;
    @(posedge CLK) disable iff (!rst_n) $rose(rst_n_q) |-> $past(rst_done) && $past(all_uv);
  endproperty
  a_rst_rel: assert property (p_rst_rel) else $error("reset released early");

  property p_mon_uv;
    @(posedge CLK) disable iff (!rst_n) (CE && mon_uv) |=> !rst_n_q;
  endproperty
  a_mon_uv: assert property (p_mon_uv) else $error("reset high on undervoltage");

  property p_uv_fault;
    @(posedge CLK) disable iff (!rst_n)
      (CE && mon_uv && uv_fault) |=> (FAULT_LINE_OE && drive_q == '0);
  endproperty
  a_uv_fault: assert property (p_uv_fault) else $error("fault did not shut supplies");

  property p_hold;
    @(posedge CLK) disable iff (!rst_n)
      (CE && phase_q == sss_pkg::SSS_FAULT && !rel_ok) |=> (flt_q && drive_q == '0);
  endproperty
  a_hold: assert property (p_hold) else $error("fault released early");

  property p_down;
    @(posedge CLK) disable iff (!rst_n)
      (CE && run_fall && !fault_set && (phase_q == sss_pkg::SSS_UP ||
       phase_q == sss_pkg::SSS_MON)) |=> (!rst_n_q && cmp_q == '0);
  endproperty
  a_down: assert property (p_down) else $error("reset or comparators high at shutdown");

  property p_ov;
    @(posedge CLK) disable iff (!rst_n) (CE && any_ov) |=> !alarm_n_q;
  endproperty
  a_ov: assert property (p_ov) else $error("alarm not raised on overvoltage");

  property p_ov_rel;
    @(posedge CLK) disable iff (!rst_n) $rose(alarm_n_q) |-> $past(ov_done) && !$past(any_ov);
  endproperty
  a_ov_rel: assert property (p_ov_rel) else $error("alarm released early");

endmodule

/* File: rtl/sss_cfg.svh */
/*
  Constants of the supply sequencer: register offsets, field positions,
  reset values and timing figures.
  Assumes a 50 MHz clock and is included by its bare name.
*/
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH

// Clock rate
`define SSS_CLK_MHZ 50

// Timer periods in microseconds
`define SSS_STMR_US 29000
`define SSS_PTMR_US 400000
`define SSS_RTMR_US 190000

// Channel and slot geometry
`define SSS_CHANNELS 4
`define SSS_POS_W 3
`define SSS_LAST_SLOT 3'h7

// Register byte offsets
`define SSS_CTRL_OFS 8'h00
`define SSS_STATUS_OFS 8'h04
`define SSS_CAUSE_OFS 8'h08

// Control fields and reset value
`define SSS_CTRL_EN_BIT 0
`define SSS_CTRL_UVF_BIT 1
`define SSS_CTRL_RST 2'h1

// Fault cause fields
`define SSS_CAUSE_UV_BIT 0
`define SSS_CAUSE_SEQ_BIT 1
`define SSS_CAUSE_EXT_BIT 2

// Three-state pin codes
`define SSS_PIN_GND 2'h0
`define SSS_PIN_OPEN 2'h1
`define SSS_PIN_VCC 2'h2

// Overvoltage margin above undervoltage, percent
`define SSS_OV_PCT_OPEN 8'h20
`define SSS_OV_PCT_GND 8'h0C
`define SSS_OV_PCT_VCC 8'h73

// Bus responses
`define SSS_RESP_OKAY 2'h0
`define SSS_RESP_SLVERR 2'h2

`endif

/* File: rtl/sss_pkg.sv */
/*
  Types of the supply sequencer.
  Assumes nothing of its surroundings.
*/
package sss_pkg;

  // Operating phase
  typedef enum logic [2:0] {
    SSS_OFF,
    SSS_UP,
    SSS_MON,
    SSS_DOWN,
    SSS_FAULT
  } sss_phase_e;

endpackage

/* File: rtl/sss_timer.sv */
/*
  Interval timer: counts enabled cycles after a restart and flags expiry.
  Assumes a synchronous restart and one clock with a clock enable.
*/
`timescale 1ns/10ps
module sss_timer #(
  parameter int unsigned LIMIT = 1
) (
  input wire logic clk,      // Clock
  input wire logic rst_n,    // Reset, active low
  input wire logic ce,       // Clock enable
  input wire logic restart,  // Clear count and flag
  output logic done_q        // Interval elapsed
);

  localparam int unsigned W = $clog2(LIMIT + 1);

  logic [W-1:0] cnt_q;

  // Count up to the limit, then hold the flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (ce) begin
      if (restart) begin
        cnt_q <= '0;
        done_q <= 1'b0;
      end else if (!done_q) begin
        cnt_q <= cnt_q + W'(1);
        done_q <= (cnt_q == W'(LIMIT - 1));
      end
    end
  end

endmodule

/* File: bench/sss_rails.sv */
/* Rail model: supplies follow their enables.
   Assumes the sequencer clock. */
`timescale 1ns/10ps
module sss_rails (
  input wire logic clk,       // Clock
  input wire logic [3:0] en,  // Enables
  input wire logic [3:0] sag, // Forced sag
  input wire logic tie,       // Alarm wired to fault
  input wire logic alarm_n,   // Alarm pin
  input wire logic oe,        // Fault pull-down
  output logic [3:0] uv_ok,   // Above undervoltage
  output logic [3:0] seq_ok,  // Above sequence level
  output logic fault_line            // Fault wire
);
  // Rails settle a cycle after the enable
  always @(posedge clk) seq_ok <= en;
  assign uv_ok = seq_ok & ~sag;
  // Pulled-up wire, alarm optionally joined
  assign fault_line = ~oe & (alarm_n | ~tie);
endmodule

/* File: bench/supply_sequencer_supervisor_bench.sv */
/* Bench of the sequencer: random slots, bus, faults.
   Assumes sss_top and the rail model. */
`timescale 1ns/10ps
module supply_sequencer_supervisor_bench;
  logic clk = 0, rst_n = 0, run = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, tie = 0;
  logic [3:0] drv, cmp, uv, sq, ov = 0, sag = 0, ws = 4'hF;
  logic [11:0] pos = 0;
  logic [1:0] ra = 1, rb = 0, hts = 1, bresp, rresp, rr;
  logic [7:0] aw = 0, ar = 0, mpct;
  logic [31:0] wd = 0, rd, v;
  logic oe, fo, fault_line, stb, done_n, rst_o, alm, awr, wr, bv, arr, rv;
  int miscompares = 0, tests_run = 0, falls = 0, seed = 32'h1B7E9419;
  sss_top #(.STMR_CYC(8), .PTMR_CYC(200), .RTMR_CYC(16)) sss_top_i (.CLK(clk), .RST_N(rst_n),
    .CE(1'b1), .RUN_REQ(run), .SUPPLY_UV_OK(uv), .SUPPLY_SEQ_OK(sq), .SUPPLY_OV(ov),
    .POSITION_SELECT(pos), .ROLE_SELECT_A(ra), .ROLE_SELECT_B(rb),
    .HIGH_THRESHOLD_SELECT(hts), .FAULT_LINE_I(fault_line), .FAULT_LINE_O(fo), .FAULT_LINE_OE(oe),
    .CHANNEL_DRIVE(drv), .COMPARATOR_GOOD(cmp), .SLOT_STROBE_N(stb), .SEQ_DONE_N(done_n),
    .RST_OUT_N(rst_o), .HIGH_SUPPLY_ALARM_N(alm), .OV_MARGIN_PCT(mpct), .AWADDR(aw),
    .AWVALID(awv), .AWREADY(awr), .WDATA(wd), .WSTRB(ws), .WVALID(wv), .WREADY(wr),
    .BRESP(bresp), .BVALID(bv), .BREADY(bre), .ARADDR(ar), .ARVALID(arv), .ARREADY(arr),
    .RDATA(rd), .RRESP(rresp), .RVALID(rv), .RREADY(rre));
  sss_rails sss_rails_i (.clk(clk), .en(drv), .sag(sag), .tie(tie), .alarm_n(alm), .oe(oe),
    .uv_ok(uv), .seq_ok(sq), .fault_line(fault_line));
  ////////////////////////////////////////
  // Clock and slot counter
  initial forever #10 clk = ~clk;
  always @(negedge stb) falls = falls + 1;
  // Helpers
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      $display("FAIL %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic pin(input int k);
    return k == 0 ? done_n : k == 1 ? rst_o : alm;
  endfunction
  task automatic wt(input int k, input logic e);
    int i;
    for (i = 0; i < 400 && pin(k) !== e; i++) @(posedge clk);
    if (i == 400) miscompares++;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk); // Keep clear of the step of the last release
    aw <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wr) wv <= 0;
    end while (awv | wv);
    do @(posedge clk); while (bv !== 1'b1);
    bre <= 0;
    chk("bresp", 0, bresp);
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk); // Keep clear of the step of the last release
    ar <= a;
    arv <= 1;
    rre <= 1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 0;
    do @(posedge clk); while (rv !== 1'b1);
    v = rd;
    rr = rresp;
    rre <= 0;
  endtask
  function automatic logic [7:0] margin(input logic [1:0] c);
    return c == 2'h0 ? 8'h0C : c == 2'h2 ? 8'h73 : 8'h20;
  endfunction
  task automatic report_and_stop;
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    #400000;
    miscompares++;
    report_and_stop;
  end
  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    cyc(6);
    axr(8'h04);
    chk("status", 32'h6000, v & 32'h7FFF);
    axr(8'h10);
    chk("unmapped", 2, rr);
    axw(8'h00, 32'h1);
    ws <= 4'h0;
    axw(8'h00, 32'h0);
    ws <= 4'hF;
    axr(8'h00);
    chk("ctrl_strb", 1, v);
    for (int c = 0; c < 3; c++) begin
      hts <= c[1:0];
      cyc(4);
      chk("margin", margin(c[1:0]), mpct);
    end
    pos <= 12'($random(seed));
    ra <= 2'h0;
    run <= 1;
    falls = 0;
    wt(0, 0);
    chk("up_slots", 8, falls);
    chk("drives_on", 4'hF, drv);
    wt(1, 1);
    cyc(2);
    chk("cmp", 4'hF, cmp);
    axr(8'h04);
    chk("phase", 2, v[2:0]);
    rb <= 2'h1;
    sag <= 4'h4;
    cyc(4);
    chk("rst_uv", 0, rst_o);
    chk("cmp_uv", 4'hB, cmp);
    chk("no_fault", 0, oe);
    sag <= 0;
    wt(1, 1);
    chk("rst_back", 1, rst_o);
    rb <= 2'h0;
    ov <= 4'($random(seed)) | 4'h1;
    cyc(4);
    chk("alarm", 0, alm);
    ov <= 0;
    cyc(12);
    chk("alarm_hold", 0, alm);
    wt(2, 1);
    chk("alarm_free", 1, alm);
    run <= 0;
    falls = 0;
    cyc(4);
    chk("rst_down", 0, rst_o);
    chk("cmp_down", 0, cmp);
    wt(0, 1);
    chk("down_slots", 8, falls);
    chk("drives_off", 0, drv);
    cyc(4);
    run <= 1;
    wt(1, 1);
    sag <= 4'($random(seed)) | 4'h2;
    cyc(4);
    chk("flt_oe", 1, oe);
    chk("drv_flt", 0, drv);
    chk("rst_flt", 0, rst_o);
    run <= 0;
    sag <= 0;
    cyc(12);
    axr(8'h04);
    chk("phase_off", 0, v[2:0]);
    axr(8'h08);
    chk("cause_uv", 1, v);
    axw(8'h08, 32'h7);
    axr(8'h08);
    chk("cause_clr", 0, v);
    tie <= 1;
    run <= 1;
    cyc(30);
    ov <= 4'h8;
    cyc(10);
    chk("drv_ov", 0, drv);
    report_and_stop;
  end
endmodule
